// file: hw/sg_dma_count_control.sv
`timescale 1ns/10ps
`include "sg_dma_cfg.svh"

// What this block does
// - read-only current count; upper half mirrors control, low half counts.
// - next-empty enable lets a hand-off raise the dma interrupt status.
// - done bit reads 0 during a list transfer, 1 once it completes.
// - writing start marks next registers valid; reads 0 while copy pending.
// - after copying next into current, start bit reads 1 again.
// - page enable gates the page-complete flag; off keeps it clear.
// - done enable lets list completion raise the dma interrupt status.
// - abort stops the transfer, drops the queued one, clears start and done.
// - direction bit 1 reads from memory, 0 writes to memory.
// - burst bit 0 writes bytes at once, 1 gathers them into bursts.
// - main-idle bit reads 1 while the main channel is not transferring.
// - main-empty bit reads 1 while main next registers hold nothing.
// - page flag sets when a marked page completes and enable is on.
// - dropping the page enable clears the page-complete flag.
// - current-page bit shows the page-interrupt mark of the current page.
// - next-page bit shows the page-interrupt mark of the next page.
// - each list entry is eight bytes: address word, control/count word.
// - main completion moves main next values into main current.
// - list current address loads only when next valid and no list is active.
// - dma interrupt status is the OR of enabled conditions, gated to host.

module sg_dma_count_control (
    // clock and reset
    input  wire logic                   clk_sys_in,
    input  wire logic                   rst_in,
    // target register port
    input  wire logic                   reg_wr_in,
    input  wire logic                   reg_rd_in,
    input  wire logic [7:0]             reg_addr_in,
    input  wire logic [31:0]            reg_wdata_in,
    output logic [31:0]                 reg_rdata_out,
    output logic                        reg_rd_valid_out,
    // list memory read port
    output logic                        mem_rd_req_out,
    output logic [31:0]                 mem_addr_out,
    input  wire logic                   mem_ack_in,
    input  wire logic [31:0]            mem_data_in,
    // main transfer datapath
    output logic                        main_start_out,
    output logic                        main_abort_out,
    output logic [31:0]                 main_addr_out,
    output logic [15:0]                 main_count_out,
    output logic                        mem_read_dir_out,
    output logic                        burst_en_out,
    input  wire logic                   main_done_in,
    // interrupts
    input  wire logic                   host_irq_enable_in,
    output logic                        dma_irq_status_out,
    output logic                        host_irq_out
);

    sg_dma_pkg::sg_ctrl_t   ctrl;
    sg_dma_pkg::sg_entry_t  main_next;
    sg_dma_pkg::sg_entry_t  main_cur;
    sg_dma_pkg::sg_entry_t  fetched;

    logic [31:0] sg_next_addr;
    logic [15:0] sg_next_count;
    logic [31:0] sg_cur_addr;
    logic [15:0] sg_cur_count;
    logic        sg_pending;
    logic        sg_active;
    logic        sg_done;
    logic        main_next_valid;
    logic        main_active;
    logic        page_complete_flag;
    logic        fetch_busy;
    logic        fetch_valid;
    logic        fetch_req;
    logic        wr_ctrl;
    logic        wr_addr;
    logic        abort_req;
    logic        handoff;
    logic        main_load;
    logic        sg_finish;
    logic [15:0] ctrl_upper;

    assign wr_ctrl   = reg_wr_in && (reg_addr_in == `SG_OFF_NEXT_CTRL);
    assign wr_addr   = reg_wr_in && (reg_addr_in == `SG_OFF_NEXT_ADDR);
    assign abort_req = wr_ctrl && reg_wdata_in[`SG_BIT_ABORT];
    // copy only when nothing of the previous list is still running
    assign handoff   = sg_pending && !sg_active && !abort_req;
    assign main_load = main_next_valid && !abort_req
                       && (!main_active || main_done_in);
    assign fetch_req = sg_active && (sg_cur_count != `SG_RST_COUNT)
                       && !main_next_valid && !fetch_busy
                       && !fetch_valid && !abort_req;
    assign sg_finish = sg_active && (sg_cur_count == `SG_RST_COUNT)
                       && !fetch_busy && !fetch_valid && !main_next_valid
                       && !main_active && !abort_req;

    // software control bits; enables and modes stay writable while busy
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            ctrl <= '0;
        end else if (wr_ctrl) begin
            ctrl.en_next_empty <= reg_wdata_in[`SG_BIT_EN_NEXT_EMPTY];
            ctrl.en_page       <= reg_wdata_in[`SG_BIT_EN_PAGE];
            ctrl.sg_complete_irq_enable    <= reg_wdata_in[`SG_BIT_SG_COMPLETE_IRQ_ENABLE];
            ctrl.mem_read      <= reg_wdata_in[`SG_BIT_MEM_RD];
            ctrl.burst         <= reg_wdata_in[`SG_BIT_BURST];
        end
    end

    assign mem_read_dir_out = ctrl.mem_read;
    assign burst_en_out     = ctrl.burst;

    // next registers; writes while a copy is pending are dropped
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            sg_next_addr  <= `SG_RST_ADDR;
            sg_next_count <= `SG_RST_COUNT;
        end else if (!sg_pending) begin
            if (wr_addr) begin
                sg_next_addr <= reg_wdata_in;
            end
            if (wr_ctrl) begin
                sg_next_count <= reg_wdata_in[15:0];
            end
        end
    end

    // start request: set by software, cleared by the copy or abort
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            sg_pending <= 1'b0;
        end else if (abort_req) begin
            sg_pending <= 1'b0;
        end else if (wr_ctrl && reg_wdata_in[`SG_BIT_START]
                     && !sg_pending) begin
            sg_pending <= 1'b1;
        end else if (handoff) begin
            sg_pending <= 1'b0;
        end
    end

    // list current address and remaining byte count
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            sg_cur_addr  <= `SG_RST_ADDR;
            sg_cur_count <= `SG_RST_COUNT;
        end else if (abort_req) begin
            sg_cur_count <= `SG_RST_COUNT;
        end else if (handoff) begin
            sg_cur_addr  <= sg_next_addr;
            sg_cur_count <= sg_next_count;
        end else if (fetch_valid) begin
            sg_cur_addr <= sg_cur_addr + `SG_ENTRY_STEP;
            if (sg_cur_count > `SG_ENTRY_BYTES) begin
                sg_cur_count <= sg_cur_count - `SG_ENTRY_BYTES;
            end else begin
                sg_cur_count <= `SG_RST_COUNT;
            end
        end
    end

    // list activity and completion status
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            sg_active <= 1'b0;
            sg_done   <= 1'b1;
        end else if (abort_req) begin
            sg_active <= 1'b0;
            sg_done   <= 1'b0;
        end else if (handoff) begin
            sg_active <= 1'b1;
            sg_done   <= 1'b0;
        end else if (sg_finish) begin
            sg_active <= 1'b0;
            sg_done   <= 1'b1;
        end
    end

    sg_list_fetch u_fetch (
        .clk_sys_in      (clk_sys_in),
        .rst_in          (rst_in),
        .abort_in        (abort_req),
        .fetch_req_in    (fetch_req),
        .fetch_addr_in   (sg_cur_addr),
        .fetch_busy_out  (fetch_busy),
        .entry_valid_out (fetch_valid),
        .entry_out       (fetched),
        .mem_rd_req_out  (mem_rd_req_out),
        .mem_addr_out    (mem_addr_out),
        .mem_ack_in      (mem_ack_in),
        .mem_data_in     (mem_data_in)
    );

    // main next registers, filled from the fetched entry
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            main_next_valid <= 1'b0;
            main_next       <= '0;
        end else if (abort_req) begin
            main_next_valid <= 1'b0;
        end else if (fetch_valid) begin
            main_next_valid <= 1'b1;
            main_next       <= fetched;
        end else if (main_load) begin
            main_next_valid <= 1'b0;
        end
    end

    // main current registers and activity
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            main_active    <= 1'b0;
            main_cur       <= '0;
            main_start_out <= 1'b0;
        end else begin
            main_start_out <= 1'b0;
            if (abort_req) begin
                main_active <= 1'b0;
            end else if (main_load) begin
                main_cur       <= main_next;
                main_active    <= 1'b1;
                main_start_out <= 1'b1;
            end else if (main_done_in) begin
                main_active <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            main_abort_out <= 1'b0;
        end else begin
            main_abort_out <= abort_req;
        end
    end

    assign main_addr_out  = main_cur.addr;
    assign main_count_out = main_cur.count;

    // flag only lives while its enable is on; no set can race the clear
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            page_complete_flag <= 1'b0;
        end else if (!ctrl.en_page) begin
            page_complete_flag <= 1'b0;
        end else if (main_done_in && main_active && main_cur.page_irq) begin
            page_complete_flag <= 1'b1;
        end
    end

    // level conditions, so the status drops as soon as its cause does
    assign dma_irq_status_out = (ctrl.en_next_empty && !sg_pending)
                                || (ctrl.sg_complete_irq_enable && sg_done)
                                || page_complete_flag;
    assign host_irq_out = dma_irq_status_out && host_irq_enable_in;

    assign ctrl_upper = {ctrl.en_next_empty, sg_done, !sg_pending,
                         ctrl.en_page, ctrl.sg_complete_irq_enable, 1'b0,
                         ctrl.mem_read, ctrl.burst, !main_active,
                         !main_next_valid, 3'h0, page_complete_flag,
                         main_cur.page_irq,
                         main_next.page_irq};

    // read data registered; unmapped offsets return zero
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            reg_rdata_out    <= `SG_RST_DATA;
            reg_rd_valid_out <= 1'b0;
        end else begin
            reg_rd_valid_out <= reg_rd_in;
            if (!reg_rd_in) begin
                reg_rdata_out <= reg_rdata_out;
            end else if (reg_addr_in == `SG_OFF_NEXT_CTRL) begin
                reg_rdata_out <= {ctrl_upper, sg_next_count};
            end else if (reg_addr_in == `SG_OFF_CUR_COUNT) begin
                reg_rdata_out <= {ctrl_upper, sg_cur_count};
            end else if (reg_addr_in == `SG_OFF_NEXT_ADDR) begin
                reg_rdata_out <= sg_next_addr;
            end else if (reg_addr_in == `SG_OFF_CUR_ADDR) begin
                reg_rdata_out <= sg_cur_addr;
            end else begin
                reg_rdata_out <= `SG_RST_DATA;
            end
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    abort_clears_a: assert property (abort_req |=>
        !sg_pending && !sg_done && !sg_active && !main_next_valid)
        else $error("abort left state behind");
    start_sets_a: assert property (
        wr_ctrl && reg_wdata_in[`SG_BIT_START] && !sg_pending && !abort_req
        |=> sg_pending ##1 (sg_pending || sg_active || $past(abort_req)))
        else $error("start write not taken");
    handoff_copy_a: assert property (handoff |=>
        !sg_pending && sg_active && sg_cur_addr == $past(sg_next_addr))
        else $error("hand-off copy wrong");
    no_early_copy_a: assert property (sg_active && !abort_req |=>
        $stable(sg_cur_addr) || $past(fetch_valid))
        else $error("current address loaded while busy");
    main_move_a: assert property (main_load |=>
        main_active && main_start_out && main_cur == $past(main_next))
        else $error("main next not moved");
    page_clear_a: assert property (!ctrl.en_page |=>
        !page_complete_flag)
        else $error("page flag survived disable");
    page_set_a: assert property (
        ctrl.en_page && main_done_in && main_active && main_cur.page_irq
        |=> page_complete_flag || !ctrl.en_page)
        else $error("page flag not set");
    handoff_irq_a: assert property ($fell(sg_pending) &&
        ctrl.en_next_empty |-> dma_irq_status_out)
        else $error("next-empty interrupt missing");
    done_irq_a: assert property ($rose(sg_done) && ctrl.sg_complete_irq_enable
        && host_irq_enable_in |-> host_irq_out)
        else $error("done interrupt missing");
    count_step_a: assert property (fetch_valid && !abort_req
        && sg_cur_count > `SG_ENTRY_BYTES && !handoff
        |=> sg_cur_count == $past(sg_cur_count) - `SG_ENTRY_BYTES)
        else $error("list count not stepped by one entry");
    idle_read_a: assert property (reg_rd_in &&
        reg_addr_in == `SG_OFF_NEXT_CTRL |=>
        reg_rdata_out[`SG_BIT_MAIN_IDLE] == !$past(main_active)
        && reg_rdata_out[`SG_BIT_ABORT] == 1'b0)
        else $error("status read wrong");

    handoff_c: cover property (handoff ##[1:200] sg_finish);
    page_c: cover property ($rose(page_complete_flag));
    abort_c: cover property (sg_active && abort_req);
    main_c: cover property (main_done_in && main_next_valid);

endmodule

// file: shared/sg_dma_cfg.svh
`ifndef SG_DMA_CFG_SVH
`define SG_DMA_CFG_SVH

// register byte offsets on the target port
`define SG_OFF_CUR_ADDR       8'h10
`define SG_OFF_NEXT_ADDR      8'h14
`define SG_OFF_CUR_COUNT      8'h18
`define SG_OFF_NEXT_CTRL      8'h1c

// bit positions in the next count/control word
`define SG_BIT_EN_NEXT_EMPTY  31
`define SG_BIT_DONE           30
`define SG_BIT_START          29
`define SG_BIT_EN_PAGE        28
`define SG_BIT_SG_COMPLETE_IRQ_ENABLE     27
`define SG_BIT_ABORT          26
`define SG_BIT_MEM_RD         25
`define SG_BIT_BURST          24
`define SG_BIT_MAIN_IDLE      23
`define SG_BIT_MAIN_EMPTY     22
`define SG_BIT_PAGE_FLAG      18
`define SG_BIT_CUR_PG         17
`define SG_BIT_NEXT_PG        16

// list entry layout
`define SG_ENTRY_PG_BIT       16
`define SG_ENTRY_BYTES        16'h0008
`define SG_ENTRY_STEP         32'h0000_0008
`define SG_WORD_STEP          32'h0000_0004

// reset values
`define SG_RST_ADDR           32'h0000_0000
`define SG_RST_COUNT          16'h0000
`define SG_RST_DATA           32'h0000_0000

`endif

// file: shared/sg_dma_pkg.sv
package sg_dma_pkg;

    // one list entry as held in the main next/current registers
    typedef struct packed {
        logic [31:0] addr;
        logic        page_irq;
        logic [15:0] count;
    } sg_entry_t;

    // software-written control bits
    typedef struct packed {
        logic en_next_empty;
        logic en_page;
        logic sg_complete_irq_enable;
        logic mem_read;
        logic burst;
    } sg_ctrl_t;

    typedef enum logic [1:0] {
        FETCH_IDLE = 2'b00,
        FETCH_ADDR = 2'b01,
        FETCH_CTRL = 2'b10
    } fetch_state_t;

endpackage

// file: hw/sg_list_fetch.sv
`timescale 1ns/10ps
`include "sg_dma_cfg.svh"

module sg_list_fetch (
    // clock and reset
    input  wire logic                   clk_sys_in,
    input  wire logic                   rst_in,
    // request from the channel
    input  wire logic                   abort_in,
    input  wire logic                   fetch_req_in,
    input  wire logic [31:0]            fetch_addr_in,
    output logic                        fetch_busy_out,
    output logic                        entry_valid_out,
    output sg_dma_pkg::sg_entry_t       entry_out,
    // memory read port
    output logic                        mem_rd_req_out,
    output logic [31:0]                 mem_addr_out,
    input  wire logic                   mem_ack_in,
    input  wire logic [31:0]            mem_data_in
);

    sg_dma_pkg::fetch_state_t state;

    assign fetch_busy_out = (state != sg_dma_pkg::FETCH_IDLE);
    assign mem_rd_req_out = (state != sg_dma_pkg::FETCH_IDLE);

    // two word reads per entry: address first, then control/count
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            state           <= sg_dma_pkg::FETCH_IDLE;
            entry_valid_out <= 1'b0;
            entry_out       <= '0;
            mem_addr_out    <= `SG_RST_ADDR;
        end else begin
            entry_valid_out <= 1'b0;
            case (state)
                sg_dma_pkg::FETCH_IDLE: begin
                    if (fetch_req_in && !abort_in) begin
                        mem_addr_out <= fetch_addr_in;
                        state        <= sg_dma_pkg::FETCH_ADDR;
                    end
                end
                sg_dma_pkg::FETCH_ADDR: begin
                    if (abort_in) begin
                        state <= sg_dma_pkg::FETCH_IDLE;
                    end else if (mem_ack_in) begin
                        entry_out.addr <= mem_data_in;
                        mem_addr_out   <= mem_addr_out + `SG_WORD_STEP;
                        state          <= sg_dma_pkg::FETCH_CTRL;
                    end
                end
                sg_dma_pkg::FETCH_CTRL: begin
                    if (abort_in) begin
                        state <= sg_dma_pkg::FETCH_IDLE;
                    end else if (mem_ack_in) begin
                        entry_out.page_irq <= mem_data_in[`SG_ENTRY_PG_BIT];
                        entry_out.count    <= mem_data_in[15:0];
                        entry_valid_out    <= 1'b1;
                        state              <= sg_dma_pkg::FETCH_IDLE;
                    end
                end
                default: begin
                    state <= sg_dma_pkg::FETCH_IDLE;
                end
            endcase
        end
    end

endmodule

// file: tb/sg_list_mem.sv
`timescale 1ns/10ps
module sg_list_mem (
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    // answer delay in cycles
    input  wire logic [3:0]  delay_in,
    // list read port
    input  wire logic        req_in,
    input  wire logic [31:0] addr_in,
    output logic             ack_out,
    output logic [31:0]      data_out
);
    logic [31:0] words [0:7];
    logic [3:0]  wait_cnt;

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            ack_out  <= 1'b0;
            wait_cnt <= 4'h0;
            data_out <= 32'h0000_0000;
        end else if (!req_in || ack_out || wait_cnt < delay_in) begin
            ack_out  <= 1'b0;
            wait_cnt <= (req_in && !ack_out) ? wait_cnt + 4'h1 : 4'h0;
            // idle bus flips the last word to its complement every cycle
            data_out <= ~data_out;
        end else begin
            ack_out  <= 1'b1;
            wait_cnt <= 4'h0;
            data_out <= words[addr_in[4:2]];
        end
    end
endmodule

// file: tb/sg_dma_count_control_tb.sv
`timescale 1ns/10ps
`include "sg_dma_cfg.svh"
module sg_dma_count_control_tb;
    typedef struct packed {
        logic [31:0] wdata;
        logic        host_en;
        logic        dir;
        logic        burst;
        logic        irq;
        logic        hirq;
    } row_t;

    logic        clk_sys_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0;
    logic [7:0]  reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0000_0000;
    logic [31:0] reg_rdata_out, mem_addr_out, main_addr_out, mem_data_in;
    logic        reg_rd_valid_out, mem_rd_req_out, mem_ack_in;
    logic        main_start_out, main_abort_out, mem_read_dir_out;
    logic        burst_en_out, dma_irq_status_out, host_irq_out;
    logic [15:0] main_count_out;
    logic        main_done_in = 1'b0;
    logic        host_irq_enable_in = 1'b0;
    logic [3:0]  mem_delay = 4'h0;
    logic [31:0] rdata;
    int          fail_count = 0;
    int          compares = 0;
    row_t        rows [0:4];
    logic        abort_seen = 1'b0;

    always #50 clk_sys_in = ~clk_sys_in;

    // abort pulse lasts one cycle, inside the write task; keep it
    always @(posedge clk_sys_in) begin
        if (main_abort_out === 1'b1)
            abort_seen <= 1'b1;
    end

    sg_dma_count_control uut (.*);
    sg_list_mem mem (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .delay_in(mem_delay), .req_in(mem_rd_req_out),
        .addr_in(mem_addr_out), .ack_out(mem_ack_in),
        .data_out(mem_data_in));

    task automatic stop_test();
        $display("fail_count %0d compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
        end
    endtask

    task automatic hang();
        fail_count++;
        $display("[FAIL] %0t wait ran out", $time);
        stop_test();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk_sys_in);
        reg_wr_in = 1'b1;
        reg_addr_in = a;
        reg_wdata_in = d;
        @(negedge clk_sys_in);
        reg_wr_in = 1'b0;
        @(negedge clk_sys_in);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        int n;
        n = 0;
        @(negedge clk_sys_in);
        reg_rd_in = 1'b1;
        reg_addr_in = a;
        @(negedge clk_sys_in);
        reg_rd_in = 1'b0;
        while (reg_rd_valid_out !== 1'b1 && n < 4) begin
            @(negedge clk_sys_in);
            n++;
        end
        if (n == 4)
            hang();
        d = reg_rdata_out;
    endtask

    // poll a status field until it settles, bounded
    task automatic poll(input logic [31:0] mask, input logic [31:0] val);
        int n;
        n = 0;
        rd(`SG_OFF_NEXT_CTRL, rdata);
        while ((rdata & mask) !== val && n < 200) begin
            rd(`SG_OFF_NEXT_CTRL, rdata);
            n++;
        end
        if (n == 200)
            hang();
    endtask

    task automatic wait_for(input int sel);
        int n;
        n = 0;
        while (n < 300 && !(sel == 0 ? main_start_out === 1'b1 :
               sel == 1 ? mem_rd_req_out === 1'b1 : abort_seen === 1'b1)) begin
            @(negedge clk_sys_in);
            n++;
        end
        if (n == 300)
            hang();
    endtask

    task automatic page_done();
        @(negedge clk_sys_in);
        main_done_in = 1'b1;
        @(negedge clk_sys_in);
        main_done_in = 1'b0;
    endtask

    initial begin
        rows[0] = {32'h8000_0000, 5'b10011};
        rows[1] = {32'h0800_0000, 5'b00010};
        rows[2] = {32'h0200_0000, 5'b11000};
        rows[3] = {32'h0100_0000, 5'b10100};
        rows[4] = {32'h1000_0000, 5'b10000};
        mem.words[0] = 32'h0000_1000;
        mem.words[1] = 32'h0001_0040;
        mem.words[2] = 32'h0000_2000;
        mem.words[3] = 32'h0000_0020;
        repeat (20) @(negedge clk_sys_in);
        rst_in = 1'b0;
        rd(`SG_OFF_NEXT_CTRL, rdata);
        chk32(rdata, 32'h60c0_0000);
        rd(`SG_OFF_CUR_COUNT, rdata);
        chk32(rdata, 32'h60c0_0000);
        rd(8'h20, rdata);
        chk32(rdata, 32'h0000_0000);
        chk1(dma_irq_status_out, 1'b0);
        foreach (rows[i]) begin
            host_irq_enable_in = rows[i].host_en;
            wr(`SG_OFF_NEXT_CTRL, rows[i].wdata);
            chk1(mem_read_dir_out, rows[i].dir);
            chk1(burst_en_out, rows[i].burst);
            chk1(dma_irq_status_out, rows[i].irq);
            chk1(host_irq_out, rows[i].hirq);
            rd(`SG_OFF_CUR_COUNT, rdata);
            chk32(rdata, rows[i].wdata | 32'h60c0_0000);
        end
        // two-entry list, first page marked for interrupt
        wr(`SG_OFF_NEXT_ADDR, 32'h0000_0100);
        wr(`SG_OFF_NEXT_CTRL, 32'h3000_0010);
        wait_for(0);
        chk32(main_addr_out, 32'h0000_1000);
        chk32({16'h0000, main_count_out}, 32'h0000_0040);
        poll(32'h0040_0000, 32'h0000_0000);
        chk32(rdata & 32'hffff_0000, 32'h3002_0000);
        rd(`SG_OFF_CUR_COUNT, rdata);
        chk32(rdata, 32'h3002_0000);
        page_done();
        wait_for(0);
        chk32(main_addr_out, 32'h0000_2000);
        rd(`SG_OFF_NEXT_CTRL, rdata);
        chk32(rdata & 32'h0006_0000, 32'h0004_0000);
        chk1(host_irq_out, 1'b1);
        wr(`SG_OFF_NEXT_CTRL, 32'h0800_0000);
        rd(`SG_OFF_NEXT_CTRL, rdata);
        chk32(rdata & 32'h0004_0000, 32'h0000_0000);
        chk1(dma_irq_status_out, 1'b0);
        page_done();
        poll(32'hc0c0_0000, 32'h40c0_0000);
        chk1(host_irq_out, 1'b1);
        // abort while the memory is slow to answer
        mem_delay = 4'h8;
        wr(`SG_OFF_NEXT_ADDR, 32'h0000_0100);
        wr(`SG_OFF_NEXT_CTRL, 32'ha000_0010);
        wait_for(1);
        chk32(mem_addr_out, 32'h0000_0100);
        chk1(dma_irq_status_out, 1'b1);
        wr(`SG_OFF_NEXT_CTRL, 32'h0400_0000);
        wait_for(2);
        @(negedge clk_sys_in);
        chk1(mem_rd_req_out, 1'b0);
        rd(`SG_OFF_NEXT_CTRL, rdata);
        chk32(rdata & 32'h6400_0000, 32'h2000_0000);
        // reset after the abort restores the idle status word
        rst_in = 1'b1;
        repeat (2) @(negedge clk_sys_in);
        rst_in = 1'b0;
        rd(`SG_OFF_NEXT_CTRL, rdata);
        chk32(rdata, 32'h60c0_0000);
        chk1(dma_irq_status_out, 1'b0);
        stop_test();
    end
endmodule
